// ---- verilog/eep_pkg.sv ----
// Constants and types for the serial EEPROM slave front end
//
// Contract
// [RULE_01] Host sends read opcode then 8-bit address; opcode bit 3 is ninth bit.
// [RULE_02] Shift addressed byte out right after the last address bit arrives.
// [RULE_03] Continued clocking advances the read pointer per byte, data stays sequential.
// [RULE_04] Read pointer wraps from the top address back to zero.
// [RULE_05] Raising chip select ends any read and stops output.
// [RULE_06] After the status read opcode, shift out the status byte.
// [RULE_07] Status read is honoured at any time, even while programming.
// [RULE_08] During programming a status read returns the full status byte.
// [RULE_09] Host polls busy bit; after it reads zero status is exact.
// [RULE_10] Host lowers pause input only while serial clock low, stays selected.
// [RULE_11] While paused, output floats and serial input is ignored, progress kept.
// [RULE_12] Host raises pause input again only while serial clock is low.
// [RULE_13] After reset: standby, write latch clear; low supply resets again.
// [RULE_14] Host issues write enable before every array or status write.
// [RULE_15] Instructions accepted only after chip select has fallen since power-up.
// [RULE_16] Finished byte, page or status write clears the write latch.
// [RULE_17] Programming starts on chip select rise after an exact clock count.
// [RULE_18] Array commands during programming are ignored; programming continues.
// [RULE_19] Unknown opcode is ignored; output floats until chip select rises.
// [RULE_20] Opcodes 06/04 write en/dis, 05/01 status rd/wr, X3 read, X2 write.
// [RULE_21] Status: bits 7-4 ones, 3-2 block protect, 1 write latch, 0 busy.
// [RULE_22] Busy bit is one while programming, zero when commands accepted.
// [RULE_23] Serial output changes on the falling serial clock edge.
// [RULE_24] While deselected, clock and data ignored; bit counters restart.
package eep_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W_DEF = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int PAGE_BITS = 4;
  localparam int PROG_CYCLES_DEF = 1000;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] WRITE_CMD = 8'h02;
  localparam logic [7:0] OP_X_MASK = 8'hF7;
  localparam int OP_NINTH_POS = 3;
  localparam logic [7:0] STATUS_FIXED = 8'hF0;
  localparam int SR_BUSY = 0;
  localparam int SR_WRITE_LATCH = 1;
  localparam int SR_BP_LOW = 2;
  localparam int SR_BP_HIGH = 3;
  localparam int SR_BP_LSB = 2;
  // Select reads low out of reset, so a pin held low gives no fall
  localparam logic [3:0] PIN_IDLE = 4'h1;
  localparam logic [4:0] BYTES_MAX = 5'h10;
  typedef enum logic [8:0] {
    ST_STANDBY = 9'h001,
    ST_OPCODE = 9'h002,
    ST_ADDR = 9'h004,
    ST_READ = 9'h008,
    ST_STATUS = 9'h010,
    ST_WDATA = 9'h020,
    ST_SRDATA = 9'h040,
    ST_WAITCS = 9'h080,
    ST_IGNORE = 9'h100
  } state_t;
endpackage

// ---- verilog/byte_fifo.sv ----
// Synchronous FIFO for write data waiting to be programmed
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrIdx;
  logic [AW-1:0] rdIdx;
  logic [AW:0] level;
  logic push;
  logic pop;

  // Depth must be a power of two; indices simply wrap
  assign inReady = (level != (AW+1)'(DEPTH));
  assign outValid = (level != '0);
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = store[rdIdx];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrIdx <= '0;
      rdIdx <= '0;
      level <= '0;
    end else if (flush) begin
      wrIdx <= '0;
      rdIdx <= '0;
      level <= '0;
    end else begin
      if (push) wrIdx <= wrIdx + 1'b1;
      if (pop) rdIdx <= rdIdx + 1'b1;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) store[wrIdx] <= inData;
  end
endmodule // byte_fifo
`default_nettype wire

// ---- verilog/eeprom_array.sv ----
// Storage array with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 8
) (
  // Clock
  input wire logic sys_clk,
  // Write port
  input wire logic write_enable_cmd,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read port
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] cells [2**ADDR_W];

  // No reset: contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (write_enable_cmd) cells[wrAddr] <= wrData;
    if (rdEn) rdData <= cells[rdAddr];
  end
endmodule // eeprom_array
`default_nettype wire

// ---- verilog/spi_eeprom_read_status_hold.sv ----
// Serial EEPROM slave: command decode, reads, status, pause, programming
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_read_status_hold #(
  parameter int ADDR_W = eep_pkg::ADDR_W_DEF,
  parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic holdN,
  output logic so,
  output logic soEn,
  // Status bits
  output logic busy,
  output logic writeLatchBit,
  output logic blockProtectLow,
  output logic blockProtectHigh
);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  eep_pkg::state_t state;
  logic [3:0] syncA, syncB;
  logic csS, sckS, siS, holdS;
  logic sckD, csD, selected, paused;
  logic rise, fall, csRise, csFall;
  logic [2:0] rxIdx, txIdx;
  logic [6:0] rxByte;
  logic [7:0] full, cmd, txByte, rdData, status, fifoOutData;
  logic byteDone, isWrite, ninth, outPhase;
  logic [ADDR_W-1:0] rdPtr, wrPtr;
  logic rdReq, rdLoad, progSr, progStart, progDone;
  logic [1:0] srVal;
  logic [4:0] dataBytes;
  logic [TW-1:0] progTimer;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoPop, fifoFlush;

  // Pins are asynchronous to sys_clk; only syncB is read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      syncA <= eep_pkg::PIN_IDLE;
      syncB <= eep_pkg::PIN_IDLE;
    end else begin
      syncA <= {csN, sck, si, holdN};
      syncB <= syncA;
    end
  end

  assign csS = syncB[3];
  assign sckS = syncB[2];
  assign siS = syncB[1];
  assign holdS = syncB[0];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sckD <= 1'b0;
      csD <= 1'b0;
    end else begin
      sckD <= sckS;
      csD <= csS;
    end
  end

  assign csRise = csS & ~csD;
  assign csFall = ~csS & csD;

  // Chip select held low through reset release does not count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) selected <= 1'b0; // [RULE_13]
    else if (csS) selected <= 1'b0;
    else if (csFall) selected <= 1'b1; // [RULE_15]
  end

  // Pause level is only taken while the serial clock is low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) paused <= 1'b0;
    else if (csS) paused <= 1'b0;
    else if (!sckS) paused <= ~holdS; // [RULE_11]
  end

  assign rise = selected & ~paused & ~csS & sckS & ~sckD; // [RULE_11]
  assign fall = selected & ~paused & ~csS & ~sckS & sckD; // [RULE_23]
  assign full = {rxByte, siS};
  assign byteDone = rise & (rxIdx == 3'h7);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxIdx <= 3'h0;
      rxByte <= 7'h00;
    end else if (csS) begin
      rxIdx <= 3'h0; // [RULE_24]
      rxByte <= 7'h00;
    end else if (rise) begin
      rxIdx <= rxIdx + 3'h1;
      rxByte <= full[6:0];
    end
  end

  // Command sequencing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= eep_pkg::ST_STANDBY; // [RULE_13]
      cmd <= 8'h00;
      isWrite <= 1'b0;
      ninth <= 1'b0;
    end else if (csS) begin
      state <= eep_pkg::ST_STANDBY; // [RULE_05]
    end else begin
      case (state)
        eep_pkg::ST_STANDBY: begin
          if (selected) state <= eep_pkg::ST_OPCODE;
        end
        eep_pkg::ST_OPCODE: begin
          if (byteDone) begin
            cmd <= full;
            ninth <= full[eep_pkg::OP_NINTH_POS]; // [RULE_01]
            if (full == eep_pkg::STATUS_READ_CMD) begin
              state <= eep_pkg::ST_STATUS; // [RULE_07]
            end else if (busy) begin
              state <= eep_pkg::ST_IGNORE; // [RULE_18]
            end else if ((full & eep_pkg::OP_X_MASK) == eep_pkg::READ_CMD) begin
              state <= eep_pkg::ST_ADDR; // [RULE_20]
              isWrite <= 1'b0;
            end else if ((full & eep_pkg::OP_X_MASK) == eep_pkg::WRITE_CMD) begin
              state <= writeLatchBit ? eep_pkg::ST_ADDR : eep_pkg::ST_IGNORE;
              isWrite <= 1'b1;
            end else if (full == eep_pkg::WRITE_ENABLE_CMD ||
                         full == eep_pkg::WRITE_DISABLE_CMD) begin
              state <= eep_pkg::ST_WAITCS;
            end else if (full == eep_pkg::STATUS_WRITE_CMD) begin
              state <= writeLatchBit ? eep_pkg::ST_SRDATA : eep_pkg::ST_IGNORE;
            end else begin
              state <= eep_pkg::ST_IGNORE; // [RULE_19]
            end
          end
        end
        eep_pkg::ST_ADDR: begin
          if (byteDone) begin
            state <= isWrite ? eep_pkg::ST_WDATA : eep_pkg::ST_READ; // [RULE_02]
          end
        end
        eep_pkg::ST_SRDATA: begin
          if (byteDone) state <= eep_pkg::ST_WAITCS;
        end
        // Any clock past the command makes the count wrong
        eep_pkg::ST_WAITCS: begin
          if (rise) state <= eep_pkg::ST_IGNORE; // [RULE_17]
        end
        eep_pkg::ST_READ, eep_pkg::ST_STATUS, eep_pkg::ST_WDATA,
        eep_pkg::ST_IGNORE: begin
          state <= state;
        end
        default: state <= eep_pkg::ST_STANDBY;
      endcase
    end
  end

  always_comb begin
    status = eep_pkg::STATUS_FIXED; // [RULE_21]
    status[eep_pkg::SR_BP_HIGH] = blockProtectHigh;
    status[eep_pkg::SR_BP_LOW] = blockProtectLow;
    status[eep_pkg::SR_WRITE_LATCH] = writeLatchBit;
    status[eep_pkg::SR_BUSY] = busy; // [RULE_22]
  end

  assign outPhase = (state == eep_pkg::ST_READ) |
                    (state == eep_pkg::ST_STATUS);
  assign soEn = outPhase & ~paused & ~csS; // [RULE_05] [RULE_11] [RULE_19]

  // Output shifter; data is fetched well inside half a serial clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdPtr <= '0;
      txByte <= 8'h00;
      txIdx <= 3'h0;
      so <= 1'b0;
      rdReq <= 1'b0;
      rdLoad <= 1'b0;
    end else begin
      rdReq <= 1'b0;
      rdLoad <= rdReq;
      if (csS) txIdx <= 3'h0; // [RULE_24]
      if (state == eep_pkg::ST_ADDR && byteDone && !isWrite) begin
        rdPtr <= ADDR_W'({ninth, full}); // [RULE_01]
        rdReq <= 1'b1; // [RULE_02]
      end else if (state == eep_pkg::ST_OPCODE && byteDone &&
                   full == eep_pkg::STATUS_READ_CMD) begin
        txByte <= status; // [RULE_06] [RULE_08]
      end else if (rdLoad) begin
        txByte <= rdData;
      end else if (fall && outPhase) begin
        so <= txByte[7]; // [RULE_23]
        txByte <= {txByte[6:0], 1'b0};
        txIdx <= txIdx + 3'h1;
        if (txIdx == 3'h7 && state == eep_pkg::ST_READ) begin
          rdPtr <= rdPtr + 1'b1; // [RULE_03] [RULE_04]
          rdReq <= 1'b1;
        end else if (txIdx == 3'h7) begin
          txByte <= status; // [RULE_06]
        end
      end
    end
  end

  // Write data collection
  assign fifoInValid = (state == eep_pkg::ST_WDATA) & byteDone;
  assign fifoPop = fifoOutValid & busy;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      dataBytes <= 5'h00;
      srVal <= 2'h0;
    end else begin
      if (state == eep_pkg::ST_ADDR && byteDone && isWrite) begin
        wrPtr <= ADDR_W'({ninth, full});
      end else if (fifoPop) begin
        wrPtr <= {wrPtr[ADDR_W-1:eep_pkg::PAGE_BITS],
                  wrPtr[eep_pkg::PAGE_BITS-1:0] + 1'b1};
      end
      if (csS) dataBytes <= 5'h00;
      else if (fifoInValid && fifoInReady &&
               dataBytes != eep_pkg::BYTES_MAX) begin
        dataBytes <= dataBytes + 5'h01;
      end
      if (state == eep_pkg::ST_SRDATA && byteDone) begin
        srVal <= full[eep_pkg::SR_BP_HIGH:eep_pkg::SR_BP_LSB];
      end
    end
  end

  // Whole bytes only, and at least one data byte for an array write
  assign progStart = csRise & (
    (state == eep_pkg::ST_WDATA && rxIdx == 3'h0 && dataBytes != 5'h00) ||
    (state == eep_pkg::ST_WAITCS && cmd == eep_pkg::STATUS_WRITE_CMD)
  ); // [RULE_17]
  // Never flush while draining into the array
  assign fifoFlush = csRise & ~busy & ~progStart;
  assign progDone = busy & (progTimer == '0);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      progTimer <= '0;
      progSr <= 1'b0;
    end else if (progStart) begin
      busy <= 1'b1; // [RULE_22]
      progTimer <= TW'(PROG_CYCLES - 1);
      progSr <= (state == eep_pkg::ST_WAITCS);
    end else if (progDone) begin
      busy <= 1'b0; // [RULE_18]
    end else if (busy) begin
      progTimer <= progTimer - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      writeLatchBit <= 1'b0; // [RULE_13]
      blockProtectLow <= 1'b0;
      blockProtectHigh <= 1'b0;
    end else if (progDone) begin
      writeLatchBit <= 1'b0; // [RULE_16]
      if (progSr) begin
        blockProtectLow <= srVal[0];
        blockProtectHigh <= srVal[1];
      end
    end else if (csRise && state == eep_pkg::ST_WAITCS) begin
      if (cmd == eep_pkg::WRITE_ENABLE_CMD) writeLatchBit <= 1'b1;
      else if (cmd == eep_pkg::WRITE_DISABLE_CMD) writeLatchBit <= 1'b0;
    end
  end

  byte_fifo #(
    .WIDTH(eep_pkg::DATA_W),
    .DEPTH(eep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flush(fifoFlush),
    .inValid(fifoInValid),
    .inData(full),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outReady(busy),
    .outData(fifoOutData)
  );

  eeprom_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(eep_pkg::DATA_W)
  ) u_array (
    .sys_clk(sys_clk),
    .write_enable_cmd(fifoPop),
    .wrAddr(wrPtr),
    .wrData(fifoOutData),
    .rdEn(rdReq),
    .rdAddr(rdPtr),
    .rdData(rdData)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence seqProgStart;
    progStart;
  endsequence
  sequence seqBusyHeld;
    busy [*4];
  endsequence

  AST_READ_START: // [RULE_02]
    assert property (state == eep_pkg::ST_ADDR && byteDone && !isWrite
      |=> state == eep_pkg::ST_READ && rdReq ##1 rdLoad)
    else $error("read data not fetched after address");
  AST_PTR_INC: // [RULE_03]
    assert property (fall && state == eep_pkg::ST_READ && txIdx == 3'h7
      |=> rdPtr == $past(rdPtr) + 1'b1)
    else $error("read pointer did not advance");
  AST_PTR_WRAP: // [RULE_04]
    assert property (fall && state == eep_pkg::ST_READ && txIdx == 3'h7 &&
      rdPtr == '1 |=> rdPtr == '0)
    else $error("read pointer did not wrap");
  AST_CS_END: // [RULE_05]
    assert property (csRise |-> !soEn ##1 state == eep_pkg::ST_STANDBY)
    else $error("chip select rise did not end transfer");
  AST_STATUS_LOAD: // [RULE_06]
    assert property (state == eep_pkg::ST_OPCODE && byteDone &&
      full == eep_pkg::STATUS_READ_CMD
      |=> state == eep_pkg::ST_STATUS && txByte == $past(status))
    else $error("status byte not loaded");
  AST_STATUS_BUSY: // [RULE_07]
    assert property (state == eep_pkg::ST_OPCODE && byteDone && busy &&
      full == eep_pkg::STATUS_READ_CMD
      |=> txByte[7:4] == 4'hF && txByte[0] && txByte[1] == writeLatchBit)
    else $error("status read refused while busy");
  AST_HOLD_FREEZE: // [RULE_11]
    assert property (paused && !csS
      |-> !soEn ##1 $stable(rxIdx) && $stable(txIdx))
    else $error("transfer moved while paused");
  AST_LATCH_CLEAR: // [RULE_16]
    assert property (progDone |=> !writeLatchBit && !busy)
    else $error("write latch not cleared after programming");
  AST_PROG_BUSY: // [RULE_17]
    assert property (seqProgStart |=> seqBusyHeld)
    else $error("programming did not hold busy");
  AST_BUSY_CAUSE: // [RULE_17]
    assert property ($rose(busy) |-> $past(progStart))
    else $error("busy rose without chip select rise");
  AST_BUSY_IGNORE: // [RULE_18]
    assert property (state == eep_pkg::ST_OPCODE && byteDone && busy &&
      full != eep_pkg::STATUS_READ_CMD |=> state == eep_pkg::ST_IGNORE)
    else $error("command accepted while busy");
  AST_BAD_OP_HIZ: // [RULE_19]
    assert property (state == eep_pkg::ST_IGNORE |-> !soEn)
    else $error("output driven after ignored opcode");
  AST_SO_FALL: // [RULE_23]
    assert property ($changed(so) |-> $past(fall))
    else $error("serial output changed off a falling edge");
  AST_FRESH_SELECT: // [RULE_24]
    assert property (csS |=> rxIdx == 3'h0 && txIdx == 3'h0)
    else $error("bit counters not cleared while deselected");
endmodule // spi_eeprom_read_status_hold
`default_nettype wire

// ---- sim/spi_host_model.sv ----
// Host serial master model driving the EEPROM pins in mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic csN,
  output logic sck,
  output logic si,
  output logic holdN,
  input wire logic so,
  input wire logic soEn
);
  logic holdEn;
  logic moved;
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
    holdEn = 1'b0;
    moved = 1'b0;
  end
  // Half of a 48 ns serial clock period
  task automatic half();
    repeat (6) @(negedge sys_clk);
  endtask
  // Fall of select opens every command
  task automatic sel();
    csN = 1'b0;
    moved = 1'b0;
    half();
  endtask
  // Rise of select ends reads, starts programming
  task automatic desel();
    half();
    csN = 1'b1;
    si = ~si;
    half();
  endtask
  // MSB first; pause before bit hp, only with clock low
  task automatic xbyte(input logic [7:0] tx, input int hp,
      output logic [7:0] rx);
    logic en;
    for (int i = 7; i >= 0; i--) begin
      if (7 - i == hp) begin
        holdN = 1'b0;
        half();
        holdEn = soEn;
        si = ~si;
        half();
        holdN = 1'b1;
      end
      si = tx[i];
      half();
      // Released line reads as the inverse of its last bit
      en = soEn;
      rx[i] = (en === 1'b1) ? so : ~so;
      sck = 1'b1;
      half();
      if (en === 1'b1 && soEn === 1'b1 && so !== rx[i]) begin
        moved = 1'b1;
      end
      sck = 1'b0;
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// ---- sim/spi_eeprom_read_status_hold_tb.sv ----
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_read_status_hold_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  wire csN, sck, si, holdN, so, soEn;
  wire busy, writeLatchBit, blockProtectLow, blockProtectHigh;
  logic enSeen = 1'b0;
  int holdByte = -1;
  logic [1:0] bp = 2'b00;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] r[$];
  logic [7:0] q[$];
  // Byte count, command, then status expected after it
  logic [23:0] rows [5] = '{24'h0106F2, 24'h0104F0, 24'h02FFF0,
    24'h0206F0, 24'h0106F2};

  always #2 sys_clk = ~sys_clk;

  spi_eeprom_read_status_hold #(.PROG_CYCLES(800)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .csN(csN), .sck(sck), .si(si),
    .holdN(holdN), .so(so), .soEn(soEn), .busy(busy),
    .writeLatchBit(writeLatchBit), .blockProtectLow(blockProtectLow),
    .blockProtectHigh(blockProtectHigh));

  spi_host_model host_u (
    .sys_clk(sys_clk), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
    .so(so), .soEn(soEn));

  always @(posedge sys_clk) begin
    if (soEn === 1'b1) begin
      enSeen <= 1'b1;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One selection carrying whole bytes; replies kept per byte
  task automatic send(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    enSeen = 1'b0;
    host_u.sel();
    foreach (tx[k]) begin
      host_u.xbyte(tx[k], (k == holdByte) ? 3 : 8, b);
      rx.push_back(b);
    end
    host_u.desel();
  endtask

  // Poll only the busy bit, bounded tries
  task automatic poll();
    logic [7:0] s[$];
    int n;
    n = 0;
    do begin
      send('{8'h05, 8'h00}, s);
      n++;
    end while (s[1][0] !== 1'b0 && n < 20);
    check(s[1], {4'hF, bp, 2'b00});
  endtask

  task automatic check_reset();
    check({4'h0, busy, writeLatchBit, blockProtectHigh, blockProtectLow},
      8'h00);
    check({7'h0, soEn}, 8'h00);
  endtask

  initial begin
    repeat (4) @(negedge sys_clk);
    check_reset();
    resetn = 1'b1;
    // Select must be seen high after release before it can fall
    repeat (4) @(negedge sys_clk);
    $display("Test reset done");
    foreach (rows[i]) begin
      q = '{rows[i][15:8]};
      if (rows[i][23:16] == 8'h02) begin
        q.push_back(8'h00);
      end
      send(q, r);
      check({7'h0, enSeen}, 8'h00);
      send('{8'h05, 8'h00}, r);
      check(r[1], rows[i][7:0]);
      $display("Test row %0d done", i);
    end
    // Latch is set by the last row
    send('{8'h02, 8'h00, 8'h5A}, r);
    poll();
    send('{8'h06}, r);
    send('{8'h0A, 8'hFE, 8'hA5, 8'h3C}, r);
    check({7'h0, busy}, 8'h01);
    send('{8'h05, 8'h00}, r);
    check(r[1], 8'hF3);
    send('{8'h0B, 8'hFE, 8'h00}, r);
    check({7'h0, enSeen}, 8'h00);
    poll();
    $display("Test write done");
    holdByte = 3;
    send('{8'h0B, 8'hFE, 8'h00, 8'h00, 8'h00}, r);
    holdByte = -1;
    check(r[2], 8'hA5);
    check(r[3], 8'h3C);
    check(r[4], 8'h5A);
    check({7'h0, host_u.holdEn}, 8'h00);
    check({7'h0, host_u.moved}, 8'h00);
    check({7'h0, soEn}, 8'h00);
    $display("Test read and pause done");
    send('{8'h06}, r);
    send('{8'h01, 8'h0C}, r);
    bp = 2'b11;
    poll();
    check({6'h0, blockProtectHigh, blockProtectLow}, 8'h03);
    $display("Test status write done");
    // Select held low through reset must not count as a fall
    resetn = 1'b0;
    host_u.csN = 1'b0;
    repeat (4) @(negedge sys_clk);
    check_reset();
    resetn = 1'b1;
    enSeen = 1'b0;
    host_u.xbyte(8'h05, 8, r[0]);
    host_u.xbyte(8'h00, 8, r[0]);
    check({7'h0, enSeen}, 8'h00);
    host_u.desel();
    $display("Test second reset done");
    print_verdict();
  end
endmodule // spi_eeprom_read_status_hold_tb
`default_nettype wire
